/* File: hdl/spri_fifo.sv */
// Word FIFO with registered read data
`timescale 1ns/100ps
`default_nettype none
module spri_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  spri_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ov;
    logic [W-1:0] od;
  } spri_fifo_st_t;

  spri_fifo_st_t s;
  spri_fifo_st_t next_s;
  logic push;
  logic load;

  // Output word sits in its own register, so capacity is DEPTH plus one
  assign port.wr_ready = (s.cnt != CNT_FULL);
  assign port.rd_valid = s.ov;
  assign port.rd_data = s.od;

  always_comb begin
    next_s = s;
    push = port.wr_valid && (s.cnt != CNT_FULL);
    load = (s.cnt != '0) && (!s.ov || port.rd_ready);
    if (s.ov && port.rd_ready) begin
      next_s.ov = 1'b0;
    end
    if (load) begin
      next_s.od = s.mem[s.rp];
      next_s.ov = 1'b1;
      next_s.rp = (s.rp == PTR_LAST) ? '0 : s.rp + 1'b1;
    end
    if (push) begin
      next_s.mem[s.wp] = port.wr_data;
      next_s.wp = (s.wp == PTR_LAST) ? '0 : s.wp + 1'b1;
    end
    case ({push, load})
      2'h2: next_s.cnt = s.cnt + 1'b1;
      2'h1: next_s.cnt = s.cnt - 1'b1;
      default: next_s.cnt = s.cnt;
    endcase
    if (port.flush) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/spri_fifo_if.sv */
// Handshake bundle between the receive shifter and the word FIFO
`timescale 1ns/100ps
`default_nettype none
interface spri_fifo_if #(
  parameter int W = 16
);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  logic flush;
  modport fifo (
    input wr_valid, wr_data, rd_ready, flush,
    output wr_ready, rd_valid, rd_data
  );
  modport user (
    output wr_valid, wr_data, rd_ready, flush,
    input wr_ready, rd_valid, rd_data
  );
endinterface
`default_nettype wire

/* File: hdl/spri_pkg.sv */
// Shared constants for the serial port ready-flag and interrupt block
package spri_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int SUBFRAME_LEN = 16;
  localparam int DIV_W = 8;
  // ----------------------------------------
  // Interrupt modes
  // ----------------------------------------
  localparam logic [1:0] IRQ_ELEMENT = 2'h0;
  localparam logic [1:0] IRQ_SUBFRAME = 2'h1;
  localparam logic [1:0] IRQ_FRAME = 2'h2;
  localparam logic [1:0] IRQ_SYNC_ERR = 2'h3;
  // ----------------------------------------
  // Pin slots in the input synchroniser
  // ----------------------------------------
  localparam int PIN_N = 6;
  localparam int PIN_TX_CLK = 0;
  localparam int PIN_TX_FS = 1;
  localparam int PIN_RX_CLK = 2;
  localparam int PIN_RX_FS = 3;
  localparam int PIN_RX_DATA = 4;
  localparam int PIN_GEN_SRC = 5;
  // Sync error flag bit positions
  localparam int ERR_RX = 0;
  localparam int ERR_TX = 1;
endpackage

/* File: hdl/spri_ready_irq.sv */
// Ready flags, interrupt modes, DMA events and rate generator of the serial port
//
// Behaviour
// - Mode 00: interrupt follows the ready flag, once per element.
// - Mode 01: receive interrupt at the end of each subframe of 16 elements; transmit subframe interrupt never fires.
// - Mode 10: interrupt on each frame sync while that direction is enabled.
// - Mode 11: interrupt on sync error; the error flag is always readable.
// - Receive ready sets when a buffered word is copied into the receive register.
// - Reading the receive register clears receive ready.
// - Receive ready clears on reset and while the receiver is held in reset.
// - Receive interrupt equals receive ready in the default mode 00.
// - Transmit ready sets when the transmit register is copied to the shifter.
// - Releasing the transmitter from reset raises transmit ready.
// - Writing the transmit register clears ready until that word is copied.
// - Writes are accepted while the shifter is still sending a word.
// - Transmit interrupt equals transmit ready in the default mode 00.
// - Ready flags double as DMA request events.
// - Holding the transmitter in reset clears its sync error.
// - Generator output goes high at first source tick, then period divider plus one.
// - A transmitter enabled late starts shifting at the next frame sync seen.
// - Receive DMA event follows receive ready; DMA reads clear it.
`timescale 1ns/100ps
`default_nettype none
module spri_ready_irq #(
  parameter int W = spri_pkg::WORD_W,
  parameter int DEPTH = spri_pkg::FIFO_DEPTH,
  parameter int SUB_LEN = spri_pkg::SUBFRAME_LEN,
  parameter int DIV_W = spri_pkg::DIV_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic serial_data_in,
  input wire logic gen_source_pin,
  output logic serial_data_out,
  input wire logic rx_reset_n,
  input wire logic tx_reset_n,
  input wire logic rate_gen_reset_n,
  input wire logic gen_source_select,
  input wire logic [DIV_W-1:0] gen_divider,
  output logic gen_bit_clock,
  input wire logic [1:0] rx_irq_mode,
  input wire logic [1:0] tx_irq_mode,
  input wire logic rx_data_read,
  output logic [W-1:0] rx_data_reg,
  input wire logic tx_data_write,
  input wire logic [W-1:0] tx_wdata,
  output logic rx_ready_flag,
  output logic tx_ready_flag,
  output logic rx_irq,
  output logic tx_irq,
  output logic rx_dma_event,
  output logic tx_dma_event,
  output logic [1:0] sync_error_flags,
  output logic tx_sync_error
);
  localparam int NP = spri_pkg::PIN_N;
  localparam int CW = $clog2(W);
  localparam int SW = $clog2(SUB_LEN);
  localparam logic [CW-1:0] BIT_LAST = CW'(W - 1);
  localparam logic [SW-1:0] SUB_LAST = SW'(SUB_LEN - 1);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [NP-1:0] s1;
    logic [NP-1:0] s2;
    logic [NP-1:0] s3;
    logic [NP-1:0] filt;
    logic rx_fs_prev;
    logic tx_fs_prev;
    logic [W-1:0] rx_shift;
    logic [CW-1:0] rx_cnt;
    logic rx_busy;
    logic rx_hold;
    logic [W-1:0] rx_data;
    logic rx_rdy;
    logic rx_err;
    logic [SW-1:0] rx_sub;
    logic rx_sub_p;
    logic rx_fs_p;
    logic [W-1:0] tx_data;
    logic tx_rdy;
    logic tx_rst_prev;
    logic [W-1:0] tx_shift;
    logic [CW-1:0] tx_cnt;
    logic tx_busy;
    logic tx_dout;
    logic tx_err;
    logic [SW-1:0] tx_sub;
    logic tx_sub_p;
    logic tx_fs_p;
    logic [DIV_W-1:0] gen_cnt;
    logic gen_run;
    logic gen_clk;
  } spri_st_t;

  spri_st_t s;
  spri_st_t next_s;
  logic [NP-1:0] pins;
  logic [NP-1:0] rise;
  logic rx_edge;
  logic tx_edge;
  logic rx_fs_ev;
  logic tx_fs_ev;
  logic gen_tick;
  logic [DIV_W:0] gen_high;
  logic [DIV_W:0] gen_pos;
  logic rx_done;

  spri_fifo_if #(.W(W)) rxq ();

  spri_fifo #(
    .W(W),
    .DEPTH(DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .port(rxq.fifo)
  );

  // ----------------------------------------
  // Pin qualification
  // ----------------------------------------
  assign pins[spri_pkg::PIN_TX_CLK] = tx_bit_clock;
  assign pins[spri_pkg::PIN_TX_FS] = tx_frame_sync;
  assign pins[spri_pkg::PIN_RX_CLK] = rx_bit_clock;
  assign pins[spri_pkg::PIN_RX_FS] = rx_frame_sync;
  assign pins[spri_pkg::PIN_RX_DATA] = serial_data_in;
  assign pins[spri_pkg::PIN_GEN_SRC] = gen_source_pin;

  // A qualified level rises when the two later stages agree on 1
  assign rise = s.s2 & s.s3 & ~s.filt;
  assign rx_edge = rise[spri_pkg::PIN_RX_CLK];
  assign tx_edge = rise[spri_pkg::PIN_TX_CLK];
  // Frame sync is taken at the bit clock edge, first high sample only
  assign rx_fs_ev = rx_edge && s.filt[spri_pkg::PIN_RX_FS] && !s.rx_fs_prev;
  assign tx_fs_ev = tx_edge && s.filt[spri_pkg::PIN_TX_FS] && !s.tx_fs_prev;
  assign gen_tick = gen_source_select ? rise[spri_pkg::PIN_GEN_SRC] : 1'b1;
  assign gen_high = (DIV_W+1)'(({1'b0, gen_divider} + 2'h2) >> 1);
  assign gen_pos = {1'b0, s.gen_cnt} + 1'b1;
  assign rx_done = rx_edge && s.rx_busy && (s.rx_cnt == BIT_LAST);

  // Completed words wait in the FIFO; a full FIFO stalls the shifter
  assign rxq.wr_valid = s.rx_hold;
  assign rxq.wr_data = s.rx_shift;
  assign rxq.rd_ready = rx_reset_n && !s.rx_rdy;
  assign rxq.flush = !rx_reset_n;

  always_comb begin
    next_s = s;
    next_s.s1 = pins;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.filt = (s.s2 & ~(s.s2 ^ s.s3)) | (s.filt & (s.s2 ^ s.s3));
    next_s.rx_sub_p = 1'b0;
    next_s.rx_fs_p = 1'b0;
    next_s.tx_sub_p = 1'b0;
    next_s.tx_fs_p = 1'b0;

    // ----------------------------------------
    // Receive side
    // ----------------------------------------
    if (rx_edge) begin
      next_s.rx_fs_prev = s.filt[spri_pkg::PIN_RX_FS];
    end
    if (!rx_reset_n) begin
      next_s.rx_busy = 1'b0;
      next_s.rx_hold = 1'b0;
      next_s.rx_rdy = 1'b0;
      next_s.rx_err = 1'b0;
      next_s.rx_sub = '0;
      next_s.rx_cnt = '0;
    end else begin
      if (s.rx_hold && rxq.wr_ready) begin
        next_s.rx_hold = 1'b0;
      end
      if (rx_fs_ev) begin
        next_s.rx_fs_p = 1'b1;
        next_s.rx_sub = '0;
        // Frame sync inside a word, or while a word is stalled, is an error
        if ((s.rx_busy && (s.rx_cnt != '0)) || s.rx_hold) begin
          next_s.rx_err = 1'b1;
        end
        if (!s.rx_hold) begin
          next_s.rx_busy = 1'b1;
          next_s.rx_cnt = '0;
        end
      end else if (rx_edge && s.rx_busy && s.rx_hold) begin
        // Overrun: rest of this frame is dropped, not merged into the stalled word
        next_s.rx_busy = 1'b0;
      end
      if (rx_edge && !s.rx_hold && (s.rx_busy || rx_fs_ev)) begin
        next_s.rx_shift = {s.rx_shift[W-2:0], s.filt[spri_pkg::PIN_RX_DATA]};
        next_s.rx_cnt = (rx_fs_ev ? '0 : s.rx_cnt) + 1'b1;
      end
      // Busy stays set: further elements follow without a new frame sync
      if (rx_done && !rx_fs_ev) begin
        next_s.rx_hold = 1'b1;
        next_s.rx_sub = (s.rx_sub == SUB_LAST) ? '0 : s.rx_sub + 1'b1;
        next_s.rx_sub_p = (s.rx_sub == SUB_LAST);
      end
      // Clear first so that a copy in the same cycle still lands
      if (rx_data_read) begin
        next_s.rx_rdy = 1'b0;
      end
      if (rxq.rd_valid && rxq.rd_ready) begin
        next_s.rx_data = rxq.rd_data;
        next_s.rx_rdy = 1'b1;
      end
    end

    // ----------------------------------------
    // Transmit side
    // ----------------------------------------
    next_s.tx_rst_prev = tx_reset_n;
    if (tx_edge) begin
      next_s.tx_fs_prev = s.filt[spri_pkg::PIN_TX_FS];
    end
    if (!tx_reset_n) begin
      next_s.tx_rdy = 1'b0;
      next_s.tx_err = 1'b0;
      next_s.tx_busy = 1'b0;
      next_s.tx_dout = 1'b0;
      next_s.tx_sub = '0;
      next_s.tx_cnt = '0;
    end else begin
      if (!s.tx_rst_prev) begin
        next_s.tx_rdy = 1'b1;
      end
      if (tx_fs_ev) begin
        next_s.tx_fs_p = 1'b1;
        if (s.tx_busy) begin
          next_s.tx_err = 1'b1;
        end
        // Shifting begins only at a frame sync seen while enabled
        next_s.tx_busy = 1'b1;
        next_s.tx_cnt = '0;
        next_s.tx_sub = '0;
        if (!s.tx_rdy && s.tx_rst_prev) begin
          next_s.tx_shift = s.tx_data;
          next_s.tx_dout = s.tx_data[W-1];
          next_s.tx_rdy = 1'b1;
          next_s.tx_sub = SW'(1);
        end else begin
          next_s.tx_dout = s.tx_shift[W-1];
        end
      end else if (tx_edge && s.tx_busy) begin
        next_s.tx_shift = {s.tx_shift[W-2:0], 1'b0};
        next_s.tx_dout = s.tx_shift[W-2];
        next_s.tx_cnt = s.tx_cnt + 1'b1;
        if (s.tx_cnt == BIT_LAST - 1'b1) begin
          next_s.tx_busy = 1'b0;
          next_s.tx_sub_p = (s.tx_sub == SUB_LAST);
        end
      end
      // The write lands after the copy, so a word written in that cycle waits
      if (tx_data_write) begin
        next_s.tx_data = tx_wdata;
        next_s.tx_rdy = 1'b0;
      end
    end

    // ----------------------------------------
    // Sample-rate generator
    // ----------------------------------------
    if (!rate_gen_reset_n) begin
      next_s.gen_run = 1'b0;
      next_s.gen_clk = 1'b0;
      next_s.gen_cnt = '0;
    end else if (gen_tick) begin
      if (!s.gen_run) begin
        next_s.gen_run = 1'b1;
        next_s.gen_clk = 1'b1;
        next_s.gen_cnt = '0;
      end else if (s.gen_cnt == gen_divider) begin
        next_s.gen_cnt = '0;
        next_s.gen_clk = 1'b1;
      end else begin
        next_s.gen_cnt = s.gen_cnt + 1'b1;
        next_s.gen_clk = (gen_pos < gen_high);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign serial_data_out = s.tx_dout;
  assign gen_bit_clock = s.gen_clk;
  assign rx_data_reg = s.rx_data;
  assign rx_ready_flag = s.rx_rdy;
  assign tx_ready_flag = s.tx_rdy;
  assign rx_dma_event = s.rx_rdy;
  assign tx_dma_event = s.tx_rdy;
  assign sync_error_flags[spri_pkg::ERR_RX] = s.rx_err;
  assign sync_error_flags[spri_pkg::ERR_TX] = s.tx_err;
  assign tx_sync_error = s.tx_err;

  always_comb begin
    case (rx_irq_mode)
      spri_pkg::IRQ_ELEMENT: rx_irq = s.rx_rdy;
      spri_pkg::IRQ_SUBFRAME: rx_irq = s.rx_sub_p;
      spri_pkg::IRQ_FRAME: rx_irq = s.rx_fs_p;
      spri_pkg::IRQ_SYNC_ERR: rx_irq = s.rx_err;
      default: rx_irq = 1'b0;
    endcase
    case (tx_irq_mode)
      spri_pkg::IRQ_ELEMENT: tx_irq = s.tx_rdy;
      spri_pkg::IRQ_SUBFRAME: tx_irq = s.tx_sub_p;
      spri_pkg::IRQ_FRAME: tx_irq = s.tx_fs_p;
      spri_pkg::IRQ_SYNC_ERR: tx_irq = s.tx_err;
      default: tx_irq = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* File: verif/spri_ready_irq_checker.sv */
// Concurrent checks on the ready, interrupt and generator ports
`timescale 1ns/100ps
`default_nettype none
module spri_ready_irq_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rx_reset_n,
  input wire logic tx_reset_n,
  input wire logic rate_gen_reset_n,
  input wire logic gen_source_select,
  input wire logic gen_bit_clock,
  input wire logic [1:0] rx_irq_mode,
  input wire logic [1:0] tx_irq_mode,
  input wire logic rx_data_read,
  input wire logic tx_data_write,
  input wire logic rx_ready_flag,
  input wire logic tx_ready_flag,
  input wire logic rx_irq,
  input wire logic tx_irq,
  input wire logic rx_dma_event,
  input wire logic tx_dma_event,
  input wire logic [1:0] sync_error_flags
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_tx_release;
    !tx_reset_n ##1 (tx_reset_n && !tx_data_write);
  endsequence
  sequence s_gen_release;
    !rate_gen_reset_n ##1 (rate_gen_reset_n && !gen_source_select);
  endsequence
  a_rx_irq_ready: assert property (rx_irq_mode == 2'h0 |-> rx_irq == rx_ready_flag)
    else $error("rx irq differs from ready");
  a_tx_irq_ready: assert property (tx_irq_mode == 2'h0 |-> tx_irq == tx_ready_flag)
    else $error("tx irq differs from ready");
  a_rx_irq_error: assert property (rx_irq_mode == 2'h3 |-> rx_irq == sync_error_flags[0])
    else $error("rx irq differs from sync error");
  a_read_clears: assert property (rx_data_read && rx_ready_flag |=> !rx_ready_flag)
    else $error("read left rx ready set");
  a_rx_hold_clear: assert property (!rx_reset_n [*2] |-> !rx_ready_flag)
    else $error("rx ready set in rx reset");
  a_write_clears: assert property (tx_data_write && tx_reset_n |=> !tx_ready_flag)
    else $error("write left tx ready set");
  a_tx_release: assert property (s_tx_release |=> tx_ready_flag)
    else $error("tx ready not raised on release");
  a_tx_err_clear: assert property (!tx_reset_n [*2] |-> !sync_error_flags[1])
    else $error("tx sync error kept in tx reset");
  a_dma_events: assert property (rx_dma_event == rx_ready_flag && tx_dma_event == tx_ready_flag)
    else $error("dma event differs from ready");
  a_gen_start: assert property (s_gen_release |-> ##[1:2] gen_bit_clock)
    else $error("generator output not raised");
endmodule
bind spri_ready_irq spri_ready_irq_checker u_chk (
  .clk_sys,
  .rst_n,
  .rx_reset_n,
  .tx_reset_n,
  .rate_gen_reset_n,
  .gen_source_select,
  .gen_bit_clock,
  .rx_irq_mode,
  .tx_irq_mode,
  .rx_data_read,
  .tx_data_write,
  .rx_ready_flag,
  .tx_ready_flag,
  .rx_irq,
  .tx_irq,
  .rx_dma_event,
  .tx_dma_event,
  .sync_error_flags
);
`default_nettype wire

/* File: verif/spri_ready_irq_tb.sv */
// Self-checking bench for the serial port ready and interrupt block
`timescale 1ns/100ps
`default_nettype none
module spri_ready_irq_tb;
  typedef struct {logic [1:0] mode; int nbits; int rx_n; int tx_n;} spri_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic rx_reset_n = 1'b0;
  logic tx_reset_n = 1'b0;
  logic rate_gen_reset_n = 1'b0;
  logic [7:0] gen_divider = 8'h03;
  logic gen_sel = 1'b0;
  logic [1:0] irq_mode = 2'h0;
  logic rx_data_read = 1'b0;
  logic tx_data_write = 1'b0;
  logic [15:0] tx_wdata = 16'h0000;
  logic auto_rd = 1'b1;
  logic [15:0] rx_exp = 16'h0000;
  logic [15:0] fill_end = 16'h0000;
  logic bclk, fsync, sdata, serial_data_out, gen_bit_clock, rx_irq_q, tx_irq_q;
  logic rx_ready_flag, tx_ready_flag, rx_irq, tx_irq, rx_dma_event, tx_dma_event;
  logic tx_sync_error;
  logic [1:0] sync_error_flags;
  logic [15:0] rx_data_reg;
  logic [31:0] cap;
  logic [7:0] pat;
  logic [2:0] watch;
  int rx_rises, tx_rises;
  int failures = 0;
  int tests_run = 0;
  // Mode, frame bits, expected rx and tx interrupt rises
  spri_row_t rows[4] = '{'{2'h0, 32, 2, 0}, '{2'h1, 256, 1, 0}, '{2'h2, 48, 1, 1},
                         '{2'h3, 32, 0, 0}};
  spri_ready_irq dut (
    .clk_sys,
    .rst_n,
    .tx_bit_clock(bclk),
    .tx_frame_sync(fsync),
    .rx_bit_clock(bclk),
    .rx_frame_sync(fsync),
    .serial_data_in(sdata),
    .gen_source_pin(bclk),
    .serial_data_out,
    .rx_reset_n,
    .tx_reset_n,
    .rate_gen_reset_n,
    .gen_source_select(gen_sel),
    .gen_divider,
    .gen_bit_clock,
    .rx_irq_mode(irq_mode),
    .tx_irq_mode(irq_mode),
    .rx_data_read,
    .rx_data_reg,
    .tx_data_write,
    .tx_wdata,
    .rx_ready_flag,
    .tx_ready_flag,
    .rx_irq,
    .tx_irq,
    .rx_dma_event,
    .tx_dma_event,
    .sync_error_flags,
    .tx_sync_error
  );
  spri_serial_peer peer (
    .bit_clock(bclk),
    .frame_sync(fsync),
    .data(sdata)
  );
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic wait_for(input int b);
    for (int n = 0; n < 3000 && watch[b] !== 1'b1; n++) @(negedge clk_sys);
    if (watch[b] !== 1'b1) begin
      failures++;
      $display("MISMATCH t=%0t wait ran out", $time);
      tally_and_finish;
    end
  endtask
  task automatic write_word(input logic [15:0] w);
    tx_wdata = w;
    tx_data_write = 1'b1;
    @(negedge clk_sys);
    tx_data_write = 1'b0;
  endtask
  // ----------------------------------------
  // Clock, monitors and the receive reader
  // ----------------------------------------
  always #10 clk_sys = ~clk_sys;
  always_comb watch = {gen_bit_clock, rx_exp == fill_end, tx_ready_flag};
  always @(posedge bclk) cap <= {cap[30:0], serial_data_out};
  always @(posedge clk_sys) begin
    rx_irq_q <= rx_irq;
    tx_irq_q <= tx_irq;
    if (rx_irq && !rx_irq_q) rx_rises++;
    if (tx_irq && !tx_irq_q) tx_rises++;
  end
  always @(negedge clk_sys) begin
    rx_data_read <= auto_rd && rx_ready_flag && !rx_data_read;
    if (auto_rd && rx_ready_flag && !rx_data_read) begin
      chk_word(rx_data_reg, rx_exp);
      rx_exp <= rx_exp + 16'h0001;
    end
  end
  initial begin
    repeat (16) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    tx_reset_n = 1'b1;
    repeat (20) @(negedge clk_sys);
    tx_reset_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk_bit(tx_sync_error, 1'b0);
    chk_bit(rx_ready_flag, 1'b0);
    rx_reset_n = 1'b1;
    tx_reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk_bit(tx_ready_flag, 1'b1);
    foreach (rows[i]) begin
      irq_mode = rows[i].mode;
      @(negedge clk_sys);
      rx_rises = 0;
      tx_rises = 0;
      peer.frame(rx_exp, rows[i].nbits);
      repeat (20) @(negedge clk_sys);
      chk_word(16'(rx_rises), 16'(rows[i].rx_n));
      chk_word(16'(tx_rises), 16'(rows[i].tx_n));
    end
    // Fill the word buffer with the reader stalled, then drain it
    irq_mode = 2'h0;
    auto_rd = 1'b0;
    fill_end = rx_exp + 16'h0011;
    peer.frame(rx_exp, 272);
    repeat (20) @(negedge clk_sys);
    chk_bit(rx_ready_flag, 1'b1);
    auto_rd = 1'b1;
    wait_for(1);
    repeat (20) @(negedge clk_sys);
    chk_bit(rx_ready_flag, 1'b0);
    write_word(16'ha5c3);
    repeat (8) @(negedge clk_sys);
    chk_bit(tx_ready_flag, 1'b0);
    fork
      peer.frame(rx_exp, 32);
      begin
        wait_for(0);
        write_word(16'h3c5a);
      end
    join
    repeat (20) @(negedge clk_sys);
    chk_word(cap[30:15], 16'ha5c3);
    chk_bit(tx_ready_flag, 1'b0);
    peer.frame(rx_exp, 32);
    repeat (20) @(negedge clk_sys);
    chk_word(cap[30:15], 16'h3c5a);
    chk_bit(tx_ready_flag, 1'b1);
    // Frame sync in mid-word on both directions
    auto_rd = 1'b0;
    irq_mode = 2'h3;
    peer.frame(rx_exp, 8);
    peer.frame(rx_exp, 16);
    repeat (20) @(negedge clk_sys);
    chk_bit(sync_error_flags[0], 1'b1);
    chk_bit(rx_irq, 1'b1);
    chk_bit(tx_irq, 1'b1);
    tx_reset_n = 1'b0;
    rx_reset_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk_bit(tx_sync_error, 1'b0);
    chk_bit(rx_ready_flag, 1'b0);
    // First frame sync passes while held in reset; enable only after it
    peer.frame(rx_exp, 16);
    tx_reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    write_word(16'h5aa5);
    repeat (8) @(negedge clk_sys);
    peer.frame(rx_exp, 32);
    repeat (20) @(negedge clk_sys);
    chk_word(cap[30:15], 16'h5aa5);
    rate_gen_reset_n = 1'b1;
    wait_for(2);
    for (int k = 0; k < 8; k++) begin
      pat = {pat[6:0], gen_bit_clock};
      @(negedge clk_sys);
    end
    chk_word({8'h00, pat}, 16'h00cc);
    // Pin source: output waits for the first qualified source edge
    rate_gen_reset_n = 1'b0;
    gen_sel = 1'b1;
    repeat (4) @(negedge clk_sys);
    rate_gen_reset_n = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk_bit(gen_bit_clock, 1'b0);
    peer.frame(rx_exp, 1);
    repeat (20) @(negedge clk_sys);
    chk_bit(gen_bit_clock, 1'b1);
    rst_n = 1'b0;
    @(negedge clk_sys);
    chk_bit(gen_bit_clock, 1'b0);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk_bit(tx_ready_flag, 1'b1);
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* File: verif/spri_serial_peer.sv */
// Far-side serial device: bit clock, frame sync and data
`timescale 1ns/100ps
`default_nettype none
module spri_serial_peer #(
  parameter int HALF_NS = 80
) (
  output var logic bit_clock,
  output var logic frame_sync,
  output var logic data
);
  initial begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    data = 1'b0;
  end
  // Element k carries base plus k, MSB first; clock stops between frames
  task automatic frame(input logic [15:0] base, input int nbits);
    logic [15:0] w;
    for (int i = 0; i < nbits; i++) begin
      w = base + 16'(i / 16);
      data = w[15 - i % 16];
      frame_sync = (i == 0);
      #(HALF_NS) bit_clock = 1'b1;
      #(HALF_NS) bit_clock = 1'b0;
    end
    frame_sync = 1'b0;
    // Released line shows the inverse, not a stale bit
    data = ~data;
  endtask
endmodule
`default_nettype wire
